// File: cpu_instruction_timing.sv
/*
 * Execute stage of a pipelined 8-bit controller core: decodes each issued opcode into
 * a cycle count, holds it for that many clocks and retires it, applying arithmetic
 * results to the accumulator, B, the program status word and the data pointer.
 * Assumes fetch supplies the opcode, its byte length, the fetched source operand and,
 * for a conditional branch, whether the condition holds, all on the same clock.
 */
// Operation
// - No instruction is held for more than eight clock cycles.
// - Runs to 25 MHz; one-cycle instructions retire back to back.
// - Instruction set of 109 opcodes with the given spread of cycle counts.
// - Opcodes, addressing and flag effects match the standard instruction set.
// - Timing counts plain clock cycles, no machine-cycle grouping.
// - Most instructions take as many cycles as they have bytes.
// - A conditional branch not taken finishes one cycle sooner.
// - Add: register 1/1, direct 2/2, indirect 1/2, immediate 2/2.
// - Add with carry adds the carry too; same sizes and cycles as add.
// - Subtract with borrow; register 1/1, direct and immediate 2/2, indirect 1/2.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_timing_defines.svh"

module cpu_instruction_timing #(
	parameter logic [3:0] MAX_CYCLES = `CIT_MAX_CYCLES
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// Issue port from fetch.
	input  wire logic        issue_valid_i,
	output logic             issue_ready_o,
	input  wire logic [7:0]  opcode_i,
	input  wire logic [2:0]  instr_bytes_i,
	input  wire logic [7:0]  operand_i,
	input  wire logic        cond_true_i,
	// Retirement and write-back.
	output logic             retire_o,
	output logic [3:0]       retire_cycles_o,
	output logic             mem_we_o,
	output logic [7:0]       mem_wdata_o,
	// Architectural state.
	output logic [7:0]       acc_o,
	output logic [7:0]       b_o,
	output logic [7:0]       program_status_word_o,
	output logic [15:0]      data_pointer_o
);

	////////////////////////////////////////////////////////////////////////////
	// Opcode decode.

	// Split the opcode into its row and column.
	wire [3:0] hi_w = opcode_i[7:4];
	wire [3:0] lo_w = opcode_i[3:0];
	wire       col_w = (lo_w >= 4'h4);

	// Arithmetic group rows.
	wire is_add  = (hi_w == 4'h2) & col_w;
	wire is_add_with_carry = (hi_w == 4'h3) & col_w;
	wire is_subtract_with_borrow = (hi_w == 4'h9) & col_w;
	wire is_inc  = (hi_w == 4'h0) & col_w;
	wire is_dec  = (hi_w == 4'h1) & col_w;
	wire is_idp  = (opcode_i == 8'ha3);
	wire is_prod = (opcode_i == 8'ha4);
	wire is_quot = (opcode_i == 8'h84);
	wire is_da   = (opcode_i == 8'hd4);
	wire is_ar   = is_add | is_add_with_carry | is_subtract_with_borrow;

	// Operand source from the column.
	cpu_timing_pkg::src_t src_w;
	assign src_w = lo_w[3] ? cpu_timing_pkg::SRC_REG :
		(lo_w[3:1] == 3'b011) ? cpu_timing_pkg::SRC_INDIRECT :
		(lo_w == 4'h5) ? cpu_timing_pkg::SRC_DIRECT :
		(is_ar ? cpu_timing_pkg::SRC_IMM : cpu_timing_pkg::SRC_ACC);

	// Register and accumulator forms take one cycle, every other source two.
	wire [3:0] src_cyc = (src_w == cpu_timing_pkg::SRC_REG ||
		src_w == cpu_timing_pkg::SRC_ACC) ? `CIT_CYC_ONE : `CIT_CYC_TWO;

	// Conditional branches: two-byte relative forms and three-byte test forms.
	wire br2_w = (opcode_i == 8'h40) | (opcode_i == 8'h50) | (opcode_i == 8'h60) |
		(opcode_i == 8'h70) | ((hi_w == 4'hd) & lo_w[3]);
	wire br3_w = (opcode_i == 8'h10) | (opcode_i == 8'h20) | (opcode_i == 8'h30) |
		((hi_w == 4'hb) & col_w) | (opcode_i == 8'hd5);
	wire is_br = br2_w | br3_w;
	wire [3:0] br_base = br2_w ? `CIT_CYC_TWO : `CIT_CYC_THREE;
	wire [3:0] br_cyc  = br_base + {3'b000, cond_true_i};

	// Operation selection.
	cpu_timing_pkg::op_t op_w;
	assign op_w = is_add ? cpu_timing_pkg::OP_ADD : is_add_with_carry ? cpu_timing_pkg::OP_ADD_WITH_CARRY :
		is_subtract_with_borrow ? cpu_timing_pkg::OP_SUBTRACT_WITH_BORROW : is_inc ? cpu_timing_pkg::OP_INC :
		is_dec ? cpu_timing_pkg::OP_DEC : is_idp ? cpu_timing_pkg::OP_INC_DATA_POINTER :
		is_prod ? cpu_timing_pkg::OP_PRODUCT : is_quot ? cpu_timing_pkg::OP_QUOTIENT :
		is_da ? cpu_timing_pkg::OP_DECIMAL_ADJUST : cpu_timing_pkg::OP_NONE;

	// Remaining opcodes take one cycle per program byte, never below one.
	wire [3:0] len_cyc = (instr_bytes_i == 3'd0) ? `CIT_CYC_ONE : {1'b0, instr_bytes_i};

	// Cycle count of the issued opcode, held to the ceiling.
	wire [3:0] raw_cyc = is_prod ? `CIT_CYC_PRODUCT : is_quot ? `CIT_CYC_QUOTIENT :
		(is_idp | is_da) ? `CIT_CYC_ONE : (is_ar | is_inc | is_dec) ? src_cyc :
		is_br ? br_cyc : len_cyc;
	wire [3:0] dec_cyc = (raw_cyc > MAX_CYCLES) ? MAX_CYCLES : raw_cyc;

	////////////////////////////////////////////////////////////////////////////
	// Execute stage sequencing.

	cpu_timing_pkg::state_t state_q, state_d;
	cpu_timing_pkg::op_t    op_q;
	cpu_timing_pkg::src_t   src_q;
	logic [3:0]             cnt_q;
	logic [3:0]             cyc_q;
	logic [7:0]             opnd_q;

	// A new opcode is taken when idle or in the last cycle of the current one.
	wire last_w     = (state_q == cpu_timing_pkg::ST_EXEC) & (cnt_q == `CIT_CYC_ONE);
	assign issue_ready_o = (state_q == cpu_timing_pkg::ST_IDLE) | last_w;
	wire issue_fire = issue_valid_i & issue_ready_o;

	// Next state of the stage.
	always_comb begin
		case (state_q)
			cpu_timing_pkg::ST_IDLE: begin
				state_d = issue_fire ? cpu_timing_pkg::ST_EXEC : cpu_timing_pkg::ST_IDLE;
			end
			cpu_timing_pkg::ST_EXEC: begin
				state_d = (last_w & ~issue_fire) ? cpu_timing_pkg::ST_IDLE : cpu_timing_pkg::ST_EXEC;
			end
			default: begin
				state_d = cpu_timing_pkg::ST_IDLE;
			end
		endcase
	end

	// Cycle counter: one count per clock, loaded at issue.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= cpu_timing_pkg::ST_IDLE;
			cnt_q   <= 4'h0;
		end else begin
			state_q <= state_d;
			cnt_q   <= issue_fire ? dec_cyc : (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
		end
	end

	// Operands latched at issue.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			op_q   <= cpu_timing_pkg::OP_NONE;
			src_q  <= cpu_timing_pkg::SRC_ACC;
			cyc_q  <= 4'h0;
			opnd_q <= `CIT_RST_BYTE;
		end else if (issue_fire) begin
			op_q   <= op_w;
			src_q  <= src_w;
			cyc_q  <= dec_cyc;
			opnd_q <= operand_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Arithmetic unit and architectural state.

	alu_if alu ();
	assign alu.op   = op_q;
	assign alu.src  = src_q;
	assign alu.acc  = acc_o;
	assign alu.b    = b_o;
	assign alu.program_status_word  = program_status_word_o;
	assign alu.opnd = opnd_q;

	cpu_arith_unit u_arith (
		.a (alu.unit)
	);

	// Increment and decrement of a register or memory byte write back outside.
	wire wr_mem = ((op_q == cpu_timing_pkg::OP_INC) | (op_q == cpu_timing_pkg::OP_DEC)) &
		(src_q != cpu_timing_pkg::SRC_ACC);

	// Results land at the end of the last cycle.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			acc_o                 <= `CIT_RST_BYTE;
			b_o                   <= `CIT_RST_BYTE;
			program_status_word_o <= `CIT_RST_BYTE;
			data_pointer_o        <= `CIT_RST_WORD;
			retire_o              <= 1'b0;
			retire_cycles_o       <= 4'h0;
			mem_we_o              <= 1'b0;
			mem_wdata_o           <= `CIT_RST_BYTE;
		end else begin
			retire_o        <= last_w;
			retire_cycles_o <= last_w ? cyc_q : 4'h0;
			mem_we_o        <= last_w & wr_mem;
			if (last_w) begin
				acc_o                 <= alu.res_acc;
				b_o                   <= alu.res_b;
				program_status_word_o <= alu.res_psw;
				mem_wdata_o           <= alu.res_mem;
				if (op_q == cpu_timing_pkg::OP_INC_DATA_POINTER) begin
					data_pointer_o <= data_pointer_o + 16'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_cycle_ceiling: assert property (cnt_q <= MAX_CYCLES)
		else $error("cycle count above the ceiling");
	a_back_to_back: assert property (issue_fire && dec_cyc == 4'h1 |=> issue_ready_o ##1 retire_o)
		else $error("one-cycle opcode did not retire at full rate");
	a_ready_last: assert property (cnt_q == `CIT_CYC_ONE |-> issue_ready_o)
		else $error("stage not ready in the last cycle of an opcode");
	a_retire_count: assert property (retire_o |-> retire_cycles_o == $past(cyc_q))
		else $error("retired cycle count mismatch");
	a_bytes_cycles: assert property (issue_fire && op_w == cpu_timing_pkg::OP_NONE && !is_br
		&& instr_bytes_i == 3'd2 |=> ##1 !retire_o ##1 retire_o)
		else $error("two-byte opcode not two cycles");
	a_branch_not_taken: assert property (issue_fire && br2_w && !cond_true_i
		|=> ##1 !retire_o ##1 retire_o)
		else $error("untaken branch not one cycle shorter");
	a_branch_taken: assert property (issue_fire && br2_w && cond_true_i
		|=> ##1 !retire_o [*2] ##1 retire_o)
		else $error("taken branch timing wrong");
	a_add_indirect: assert property (issue_fire && (is_add || is_add_with_carry) &&
		src_w == cpu_timing_pkg::SRC_INDIRECT |=> ##1 !retire_o ##1 retire_o)
		else $error("indirect add not two cycles");
	a_subtract_with_borrow_register: assert property (issue_fire && is_subtract_with_borrow && src_w == cpu_timing_pkg::SRC_REG
		|=> ##1 retire_o)
		else $error("register subtract not one cycle");
	a_product_cycles: assert property (issue_fire && is_prod |=> ##1 !retire_o [*3] ##1 retire_o)
		else $error("product not four cycles");
	a_quotient_cycles: assert property (issue_fire && is_quot |=> ##1 !retire_o [*7] ##1 retire_o)
		else $error("quotient not eight cycles");
	a_carry_added: assert property (retire_o && $past(op_q) == cpu_timing_pkg::OP_ADD_WITH_CARRY |->
		acc_o == 8'($past(acc_o) + $past(opnd_q) + {7'h00, $past(program_status_word_o[7])}))
		else $error("add with carry result wrong");

endmodule : cpu_instruction_timing

`default_nettype wire

// File: cpu_timing_defines.svh
/*
 * Constants of the instruction timing core: flag positions, cycle counts and clock figures.
 * Assumes it is included by its bare name by every file that needs a figure.
 */
`ifndef CPU_TIMING_DEFINES_SVH
`define CPU_TIMING_DEFINES_SVH

// Flag positions in the program status word.
`define CIT_PSW_CY 7
`define CIT_PSW_AC 6
`define CIT_PSW_OV 2
`define CIT_PSW_P 0

// Reset values of the architectural registers.
`define CIT_RST_BYTE 8'h00
`define CIT_RST_WORD 16'h0000

// Clock figures: top rate in MHz and the period of this build in ns.
`define CIT_CLK_MAX_MHZ 25
`define CIT_CLK_PERIOD_NS 5

// Cycle counts of the timing table.
`define CIT_MAX_CYCLES 4'd8
`define CIT_CYC_ONE 4'd1
`define CIT_CYC_TWO 4'd2
`define CIT_CYC_THREE 4'd3
`define CIT_CYC_PRODUCT 4'd4
`define CIT_CYC_QUOTIENT 4'd8

`endif

// File: cpu_timing_pkg.sv
/*
 * Types of the instruction timing core: operations, operand sources and states.
 * Assumes nothing of its surroundings.
 */
package cpu_timing_pkg;

	// Operation carried out at retirement.
	typedef enum logic [3:0] {
		OP_NONE, OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_INC, OP_DEC,
		OP_INC_DATA_POINTER, OP_PRODUCT, OP_QUOTIENT, OP_DECIMAL_ADJUST
	} op_t;

	// Where the source or target operand lives.
	typedef enum logic [2:0] {SRC_ACC, SRC_DIRECT, SRC_INDIRECT, SRC_IMM, SRC_REG} src_t;

	// Execute stage state.
	typedef enum logic {ST_IDLE, ST_EXEC} state_t;

endpackage : cpu_timing_pkg

// File: alu_if.sv
/*
 * Carrier between the timing core and its arithmetic unit.
 * Assumes both ends sit on the same clock; the unit is purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

interface alu_if;
	cpu_timing_pkg::op_t  op;
	cpu_timing_pkg::src_t src;
	logic [7:0]           acc;
	logic [7:0]           b;
	logic [7:0]           program_status_word;
	logic [7:0]           opnd;
	logic [7:0]           res_acc;
	logic [7:0]           res_b;
	logic [7:0]           res_mem;
	logic [7:0]           res_psw;

	modport core (output op, src, acc, b, program_status_word, opnd, input res_acc, res_b, res_mem, res_psw);
	modport unit (input op, src, acc, b, program_status_word, opnd, output res_acc, res_b, res_mem, res_psw);
endinterface : alu_if

`default_nettype wire

// File: cpu_arith_unit.sv
/*
 * Arithmetic group datapath: add, add with carry, subtract with borrow, increment,
 * decrement, product, quotient and decimal adjust, with their flag effects.
 * Assumes the core holds the operands stable and takes the results at retirement.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpu_timing_defines.svh"

module cpu_arith_unit (
	// Operands in, results out.
	alu_if.unit a
);

	////////////////////////////////////////////////////////////////////////////
	// Adder shared by add, add with carry and subtract with borrow.

	// Subtraction is done as addition of the inverted operand and inverted borrow.
	wire       sub_w = (a.op == cpu_timing_pkg::OP_SUBTRACT_WITH_BORROW);
	wire       cy_w  = a.program_status_word[`CIT_PSW_CY];
	wire [7:0] y_w   = sub_w ? ~a.opnd : a.opnd;
	wire       c0_w  = sub_w ? ~cy_w : ((a.op == cpu_timing_pkg::OP_ADD_WITH_CARRY) & cy_w);
	wire [8:0] s9_w  = {1'b0, a.acc} + {1'b0, y_w} + {8'h00, c0_w};
	wire [4:0] s4_w  = {1'b0, a.acc[3:0]} + {1'b0, y_w[3:0]} + {4'h0, c0_w};
	wire [7:0] s7_w  = {1'b0, a.acc[6:0]} + {1'b0, y_w[6:0]} + {7'h00, c0_w};
	wire       cy_n  = s9_w[8] ^ sub_w;
	wire       ac_n  = s4_w[4] ^ sub_w;
	wire       ov_n  = s7_w[7] ^ s9_w[8];

	// Increment and decrement work on the accumulator or on the fetched operand.
	wire [7:0] tgt_w = (a.src == cpu_timing_pkg::SRC_ACC) ? a.acc : a.opnd;
	wire [7:0] stp_w = (a.op == cpu_timing_pkg::OP_DEC) ? tgt_w - 8'h01 : tgt_w + 8'h01;

	// Product and quotient; a zero divisor leaves both registers unchanged.
	wire [15:0] prod_w = {8'h00, a.acc} * {8'h00, a.b};
	wire        dz_w   = (a.b == 8'h00);
	wire [7:0]  quo_w  = dz_w ? a.acc : a.acc / a.b;
	wire [7:0]  rem_w  = dz_w ? a.b : a.acc % a.b;

	// Decimal adjust corrects each nibble in turn; the carry is only ever set.
	wire       lo_fix = (a.acc[3:0] > 4'h9) | a.program_status_word[`CIT_PSW_AC];
	wire [8:0] da1_w  = {1'b0, a.acc} + (lo_fix ? 9'h006 : 9'h000);
	wire       hi_fix = (da1_w[7:4] > 4'h9) | cy_w | da1_w[8];
	wire [8:0] da2_w  = {1'b0, da1_w[7:0]} + (hi_fix ? 9'h060 : 9'h000);

	////////////////////////////////////////////////////////////////////////////
	// Result selection per operation.

	always_comb begin
		a.res_acc = a.acc;
		a.res_b   = a.b;
		a.res_mem = stp_w;
		a.res_psw = a.program_status_word;
		case (a.op)
			cpu_timing_pkg::OP_ADD, cpu_timing_pkg::OP_ADD_WITH_CARRY, cpu_timing_pkg::OP_SUBTRACT_WITH_BORROW: begin
				a.res_acc                = s9_w[7:0];
				a.res_psw[`CIT_PSW_CY]   = cy_n;
				a.res_psw[`CIT_PSW_AC]   = ac_n;
				a.res_psw[`CIT_PSW_OV]   = ov_n;
			end
			cpu_timing_pkg::OP_INC, cpu_timing_pkg::OP_DEC: begin
				if (a.src == cpu_timing_pkg::SRC_ACC) begin
					a.res_acc = stp_w;
				end
			end
			cpu_timing_pkg::OP_PRODUCT: begin
				a.res_acc              = prod_w[7:0];
				a.res_b                = prod_w[15:8];
				a.res_psw[`CIT_PSW_CY] = 1'b0;
				a.res_psw[`CIT_PSW_OV] = (prod_w[15:8] != 8'h00);
			end
			cpu_timing_pkg::OP_QUOTIENT: begin
				a.res_acc              = quo_w;
				a.res_b                = rem_w;
				a.res_psw[`CIT_PSW_CY] = 1'b0;
				a.res_psw[`CIT_PSW_OV] = dz_w;
			end
			cpu_timing_pkg::OP_DECIMAL_ADJUST: begin
				a.res_acc              = da2_w[7:0];
				a.res_psw[`CIT_PSW_CY] = cy_w | da1_w[8] | da2_w[8];
			end
			default: begin
				a.res_acc = a.acc;
			end
		endcase
		a.res_psw[`CIT_PSW_P] = ^a.res_acc;
	end

endmodule : cpu_arith_unit

`default_nettype wire

// File: cpu_instruction_timing_bench.sv
/*
 * Self-checking bench of the instruction timing core: cycle counts, arithmetic results,
 * back-to-back issue and reset.
 * Assumes the core's own assertions sit inside the design files.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpu_timing_defines.svh"

module cpu_instruction_timing_bench;

	logic        clk_i;
	logic        sys_rst_i;
	logic        issue_valid_i;
	logic        issue_ready_o;
	logic [7:0]  opcode_i;
	logic [2:0]  instr_bytes_i;
	logic [7:0]  operand_i;
	logic        cond_true_i;
	logic        retire_o;
	logic [3:0]  retire_cycles_o;
	logic        mem_we_o;
	logic [7:0]  mem_wdata_o;
	logic [7:0]  acc_o;
	logic [7:0]  b_o;
	logic [7:0]  program_status_word_o;
	logic [15:0] data_pointer_o;
	logic        got_we;
	logic [7:0]  got_wd;
	int          fails;
	int          n_compared;

	// Opcode, byte count, branch condition and expected cycles, one nibble or byte each.
	logic [19:0] tbl [0:38] = '{
		20'h28101, 20'h25202, 20'h26102, 20'h24202, 20'h38101, 20'h35202, 20'h36102,
		20'h34202, 20'h98101, 20'h95202, 20'h96102, 20'h94202, 20'h04101, 20'h08101,
		20'h05202, 20'h06102, 20'h14101, 20'h18101, 20'h15202, 20'h16102, 20'ha3101,
		20'ha4104, 20'h84108, 20'hd4101, 20'h60202, 20'h60213, 20'h10303, 20'h10314,
		20'hb4303, 20'hb4314, 20'hd8202, 20'hd8213, 20'h00101, 20'h75303, 20'he5202,
		20'h00001, 20'h02303, 20'h74202, 20'he4101};

	cpu_instruction_timing u_dut (
		.clk_i                 (clk_i),
		.sys_rst_i             (sys_rst_i),
		.issue_valid_i         (issue_valid_i),
		.issue_ready_o         (issue_ready_o),
		.opcode_i              (opcode_i),
		.instr_bytes_i         (instr_bytes_i),
		.operand_i             (operand_i),
		.cond_true_i           (cond_true_i),
		.retire_o              (retire_o),
		.retire_cycles_o       (retire_cycles_o),
		.mem_we_o              (mem_we_o),
		.mem_wdata_o           (mem_wdata_o),
		.acc_o                 (acc_o),
		.b_o                   (b_o),
		.program_status_word_o (program_status_word_o),
		.data_pointer_o        (data_pointer_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Compare tasks and the closing task.

	task automatic chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: bit got %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: value got %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////////////////////
	// Issues one opcode and checks the moment of its retirement and the stall in between.

	task automatic run_op(input logic [7:0] op, input logic [2:0] nb, input logic [7:0] opd,
			input logic c, input logic [3:0] n);
		int i;
		@(negedge clk_i);
		issue_valid_i = 1'b1;
		opcode_i      = op;
		instr_bytes_i = nb;
		operand_i     = opd;
		cond_true_i   = c;
		i = 0;
		while (issue_ready_o !== 1'b1 && i < 20) begin
			@(negedge clk_i);
			i++;
		end
		@(posedge clk_i);
		@(negedge clk_i);
		issue_valid_i = 1'b0;
		for (i = 1; i <= n; i++) begin
			@(posedge clk_i);
			#1;
			if (i < n) chk_bit(retire_o, 1'b0);
			if (i == 1 && n > 2) chk_bit(issue_ready_o, 1'b0);
			if (i == n - 1) chk_bit(issue_ready_o, 1'b1);
		end
		chk_bit(retire_o, 1'b1);
		chk_val({12'h000, retire_cycles_o}, {12'h000, n});
		got_we = mem_we_o;
		got_wd = mem_wdata_o;
	endtask : run_op

	// Runs an arithmetic opcode and checks accumulator and flags afterwards.
	task automatic arith(input logic [7:0] op, input logic [7:0] opd, input logic [3:0] n,
			input logic [7:0] eacc, input logic [7:0] epsw);
		run_op(op, 3'h1, opd, 1'b0, n);
		chk_val({8'h00, acc_o}, {8'h00, eacc});
		chk_val({8'h00, program_status_word_o}, {8'h00, epsw});
	endtask : arith

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios.

	// Walks the arithmetic group from reset through carries, borrows and overflows.
	task automatic test_values();
		arith(8'h24, 8'h7f, 4'h2, 8'h7f, 8'h01);
		arith(8'h28, 8'h01, 4'h1, 8'h80, 8'h45);
		arith(8'h35, 8'h80, 4'h2, 8'h00, 8'h84);
		arith(8'h34, 8'h01, 4'h2, 8'h02, 8'h01);
		arith(8'h94, 8'h03, 4'h2, 8'hff, 8'hc0);
		arith(8'h96, 8'h0f, 4'h2, 8'hef, 8'h41);
		arith(8'h04, 8'h00, 4'h1, 8'hf0, 8'h40);
		arith(8'h05, 8'hff, 4'h2, 8'hf0, 8'h40);
		chk_bit(got_we, 1'b1);
		chk_val({8'h00, got_wd}, 16'h0000);
		arith(8'h18, 8'h00, 4'h1, 8'hf0, 8'h40);
		chk_bit(got_we, 1'b1);
		chk_val({8'h00, got_wd}, 16'h00ff);
		arith(8'ha3, 8'h00, 4'h1, 8'hf0, 8'h40);
		chk_val(data_pointer_o, 16'h0001);
		arith(8'ha4, 8'h00, 4'h4, 8'h00, 8'h40);
		chk_val({8'h00, b_o}, 16'h0000);
		arith(8'h84, 8'h00, 4'h8, 8'h00, 8'h44);
		arith(8'hd4, 8'h00, 4'h1, 8'h06, 8'h44);
	endtask : test_values

	// Holds valid over four one-cycle increments; each must retire on the next edge.
	task automatic test_back_to_back();
		int k;
		@(negedge clk_i);
		issue_valid_i = 1'b1;
		opcode_i      = 8'h04;
		for (k = 0; k <= 4; k++) begin
			@(posedge clk_i);
			#1;
			if (k > 0) chk_bit(retire_o, 1'b1);
			if (k < 4) chk_bit(issue_ready_o, 1'b1);
			if (k == 3) begin
				@(negedge clk_i);
				issue_valid_i = 1'b0;
			end
		end
		chk_val({8'h00, acc_o}, 16'h000a);
		chk_val({8'h00, program_status_word_o}, 16'h0044);
	endtask : test_back_to_back

	// Every timing class of the table, branches both ways.
	task automatic test_table();
		int i;
		for (i = 0; i < 39; i++) begin
			run_op(tbl[i][19:12], tbl[i][10:8], 8'h00, tbl[i][4], tbl[i][3:0]);
		end
	endtask : test_table

	// Resets in the middle of a long opcode; everything must clear and work again.
	task automatic test_reset();
		@(negedge clk_i);
		issue_valid_i = 1'b1;
		opcode_i      = 8'h84;
		@(negedge clk_i);
		issue_valid_i = 1'b0;
		sys_rst_i     = 1'b1;
		repeat (2) @(negedge clk_i);
		chk_bit(issue_ready_o, 1'b1);
		chk_bit(retire_o, 1'b0);
		chk_val({acc_o, b_o}, 16'h0000);
		chk_val({8'h00, program_status_word_o}, 16'h0000);
		chk_val(data_pointer_o, 16'h0000);
		sys_rst_i = 1'b0;
		arith(8'h04, 8'h00, 4'h1, 8'h01, 8'h01);
		arith(8'h24, 8'hf9, 4'h2, 8'hfa, 8'h00);
		arith(8'hd4, 8'h00, 4'h1, 8'h60, 8'h80);
	endtask : test_reset

	////////////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and main sequence.

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	initial begin
		#50000;
		fails++;
		finish_test();
	end

	initial begin
		fails         = 0;
		n_compared    = 0;
		sys_rst_i     = 1'b1;
		issue_valid_i = 1'b0;
		opcode_i      = 8'h00;
		instr_bytes_i = 3'h1;
		operand_i     = 8'h00;
		cond_true_i   = 1'b0;
		repeat (2) @(negedge clk_i);
		sys_rst_i = 1'b0;
		test_values();
		test_back_to_back();
		test_table();
		test_reset();
		finish_test();
	end

endmodule : cpu_instruction_timing_bench

`default_nettype wire
